// >>> hw/sdc_pkg.sv
/*
 sdc_pkg: constants and types of the sdram command state logic.
 assumes one clock shared with the memory controller.
*/
package sdc_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 13;
  localparam int COL_W = 10;
  localparam int AP_BIT = 10;
  localparam int DQ_W = 32;
  localparam int BYTES = 4;
  localparam int RD_LAT_DEF = 3;
  localparam int BURST_LEN_DEF = 4;
  localparam int MAX_BURST = 8;
  localparam int ST_ROW_W = 2;
  localparam int ST_COL_W = 4;
  localparam int WBUF_DEPTH = 8;
  localparam int RST_STAGES = 2;

  typedef enum logic [2:0] {
    SDC_MRS = 3'h0, SDC_REF = 3'h1, SDC_PRE = 3'h2, SDC_ACT = 3'h3,
    SDC_WR = 3'h4, SDC_RD = 3'h5, SDC_STOP = 3'h6, SDC_NOP = 3'h7
  } sdc_cmd_t;

  typedef enum logic [1:0] {SDC_ACTIVE, SDC_PDOWN, SDC_SELF} sdc_power_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [BYTES-1:0] dqm;
  } sdc_pins_t;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [DQ_W-1:0] data;
    logic [BYTES-1:0] be;
  } sdc_beat_t;
endpackage

// >>> hw/sdc_core.sv
/*
 sdram command state logic: command decode, bank state,
 burst engine, read pipeline, write buffer and storage.
 assumes the controller drives clk and every pin on it.
*/
`timescale 1ns/1ps
`default_nettype none

module sdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic rdy_reg, rdy_next;
  logic push, pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("sdc_fifo: DEPTH must be a power of two");
  end

  always_comb begin
    push = in_valid && rdy_reg;
    pop = out_ready && (cnt_reg != '0);
    wp_next = wp_reg + PW'(push);
    rp_next = rp_reg + PW'(pop);
    cnt_next = cnt_reg + CW'(push) - CW'(pop);
    rdy_next = cnt_next != CW'(DEPTH);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  assign in_ready = rdy_reg;
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rp_reg];
endmodule

////////////////////////////////////////////////////////////////////////

module sdc_core #(
  parameter int RD_LAT = sdc_pkg::RD_LAT_DEF,
  parameter int BURST_LEN = sdc_pkg::BURST_LEN_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // command pins
  input wire sdc_pkg::sdc_pins_t pins,
  // data pins
  input wire logic [sdc_pkg::DQ_W-1:0] dq_in,
  output logic [sdc_pkg::DQ_W-1:0] dq_out,
  output logic [sdc_pkg::BYTES-1:0] dq_oe,
  // status
  output logic [sdc_pkg::NUM_BANKS-1:0] bank_open,
  output var sdc_pkg::sdc_power_t power_state,
  output logic suspended,
  output logic illegal_cmd,
  output logic wbuf_ready
);
  import sdc_pkg::*;

  localparam int LAST = RD_LAT - 1;
  localparam int AW = BANK_W + ST_ROW_W + ST_COL_W;
  localparam logic [COL_W-1:0] WRAP = COL_W'(BURST_LEN - 1);
  localparam logic [3:0] BLEN = 4'(BURST_LEN);

  if (RD_LAT < 2 || RD_LAT > 3 || BURST_LEN > MAX_BURST ||
      (BURST_LEN & (BURST_LEN - 1)) != 0) begin : g_chk
    $error("sdc_core: unsupported latency or burst length");
  end

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic [RST_STAGES-1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= '0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[RST_STAGES-2:0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[RST_STAGES-1];

  ////////////////////////////////////////////////////////////////////////
  // command decode and bank state

  sdc_power_t power_reg, power_next;
  logic cke_prev_reg, cke_prev_next;
  logic susp_reg, susp_next;
  logic ill_reg, ill_next;
  logic [NUM_BANKS-1:0] open_reg, open_next;
  logic [ADDR_W-1:0] row_reg [NUM_BANKS];
  logic [ADDR_W-1:0] row_next [NUM_BANKS];
  logic bon_reg, bon_next;
  logic bwr_reg, bwr_next;
  logic bap_reg, bap_next;
  logic [BANK_W-1:0] bbank_reg, bbank_next;
  logic [ADDR_W-1:0] brow_reg, brow_next;
  logic [COL_W-1:0] bcol_reg, bcol_next;
  logic [3:0] bleft_reg, bleft_next;
  logic [BYTES-1:0] dqm_q_reg;
  logic run, all_idle, fetch, push;
  logic [NUM_BANKS-1:0] close;
  logic [AW-1:0] cur_idx;
  sdc_cmd_t cmd;
  sdc_beat_t beat;

  // internal clock runs only when the gate was high last edge
  assign run = cke_prev_reg;
  assign cmd = pins.cs_n ? SDC_NOP
             : sdc_cmd_t'({pins.ras_n, pins.cas_n, pins.we_n});
  assign all_idle = (open_reg == '0) && !bon_reg;

  always_comb begin
    power_next = power_reg;
    cke_prev_next = pins.cke;
    ill_next = 1'b0;
    open_next = open_reg;
    row_next = row_reg;
    bon_next = bon_reg;
    bwr_next = bwr_reg;
    bap_next = bap_reg;
    bbank_next = bbank_reg;
    brow_next = brow_reg;
    bcol_next = bcol_reg;
    bleft_next = bleft_reg;
    close = '0;
    fetch = 1'b0;
    push = 1'b0;
    cur_idx = '0;
    beat = '0;
    unique case (power_reg)
      SDC_PDOWN: begin
        // exit acts on the rising gate edge itself
        if (pins.cke) begin
          power_next = SDC_ACTIVE;
          ill_next = !pins.cs_n;
        end
      end
      SDC_SELF: begin
        if (pins.cke) begin
          power_next = SDC_ACTIVE;
          ill_next = cmd != SDC_NOP;
        end
      end
      SDC_ACTIVE: begin
        if (run) begin
          unique case (cmd)
            SDC_ACT: begin
              if (open_reg[pins.bank]) begin
                ill_next = 1'b1;
              end else begin
                open_next[pins.bank] = 1'b1;
                row_next[pins.bank] = pins.addr;
              end
            end
            SDC_RD, SDC_WR: begin
              if (!open_reg[pins.bank]) begin
                ill_next = 1'b1;
              end else begin
                // a new column command replaces any running burst
                bon_next = 1'b1;
                bwr_next = cmd == SDC_WR;
                bap_next = pins.addr[AP_BIT];
                bbank_next = pins.bank;
                brow_next = row_reg[pins.bank];
                bcol_next = pins.addr[COL_W-1:0];
                bleft_next = BLEN;
              end
            end
            SDC_PRE: begin
              close = pins.addr[AP_BIT] ? '1
                    : NUM_BANKS'(1) << pins.bank;
              if (close[bbank_reg]) begin
                bon_next = 1'b0;
              end
            end
            SDC_STOP: begin
              // read tail still drains from the pipe
              bon_next = 1'b0;
            end
            SDC_REF, SDC_MRS: begin
              ill_next = !all_idle;
            end
            SDC_NOP: begin
              ill_next = 1'b0;
            end
          endcase
          if (bon_next) begin
            cur_idx = {bbank_next, brow_next[ST_ROW_W-1:0],
                       bcol_next[ST_COL_W-1:0]};
            fetch = !bwr_next;
            // a fully masked beat never reaches the buffer
            push = bwr_next && (pins.dqm != '1);
            beat.bank = bbank_next;
            beat.row = brow_next;
            beat.col = bcol_next;
            beat.data = dq_in;
            beat.be = ~pins.dqm;
            bcol_next = (bcol_next & ~WRAP) | ((bcol_next + COL_W'(1)) & WRAP);
            bleft_next = bleft_next - 4'h1;
            if (bleft_next == 4'h0) begin
              bon_next = 1'b0;
              if (bap_next) begin
                close[bbank_next] = 1'b1;
              end
            end
          end
          open_next = open_next & ~close;
          if (!pins.cke) begin
            if (cmd == SDC_REF && all_idle) begin
              power_next = SDC_SELF;
            end else if (pins.cs_n && all_idle) begin
              // busy banks give clock suspend instead
              power_next = SDC_PDOWN;
            end
          end
        end
      end
      default: begin
        power_next = SDC_ACTIVE;
      end
    endcase
    susp_next = (power_next == SDC_ACTIVE) && !pins.cke;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_reg <= SDC_ACTIVE;
      cke_prev_reg <= 1'b0;
      susp_reg <= 1'b0;
      ill_reg <= 1'b0;
      open_reg <= '0;
      for (int i = 0; i < NUM_BANKS; i++) begin
        row_reg[i] <= '0;
      end
      bon_reg <= 1'b0;
      bwr_reg <= 1'b0;
      bap_reg <= 1'b0;
      bbank_reg <= '0;
      brow_reg <= '0;
      bcol_reg <= '0;
      bleft_reg <= 4'h0;
      dqm_q_reg <= '0;
    end else begin
      power_reg <= power_next;
      cke_prev_reg <= cke_prev_next;
      susp_reg <= susp_next;
      ill_reg <= ill_next;
      open_reg <= open_next;
      row_reg <= row_next;
      bon_reg <= bon_next;
      bwr_reg <= bwr_next;
      bap_reg <= bap_next;
      bbank_reg <= bbank_next;
      brow_reg <= brow_next;
      bcol_reg <= bcol_next;
      bleft_reg <= bleft_next;
      dqm_q_reg <= pins.dqm;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write buffer and storage

  logic [DQ_W-1:0] store [2**AW];
  logic drain_valid, drain_ready;
  sdc_beat_t drain;
  logic [AW-1:0] widx;

  sdc_fifo #(.WIDTH($bits(sdc_beat_t)), .DEPTH(WBUF_DEPTH)) u_wbuf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(wbuf_ready),
    .in_data(beat),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain)
  );

  // single port store: a read fetch stalls the drain
  assign drain_ready = !fetch;
  assign widx = {drain.bank, drain.row[ST_ROW_W-1:0], drain.col[ST_COL_W-1:0]};

  always_ff @(posedge clk) begin
    for (int b = 0; b < BYTES; b++) begin
      if (drain_valid && drain_ready && drain.be[b]) begin
        store[widx][8*b +: 8] <= drain.data[8*b +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read pipeline

  logic [DQ_W-1:0] pd_reg [RD_LAT];
  logic [DQ_W-1:0] pd_next [RD_LAT];
  logic [RD_LAT-1:0] pv_reg, pv_next;
  logic [BYTES-1:0] oe_reg, oe_next;

  always_comb begin
    pd_next = pd_reg;
    pv_next = pv_reg;
    oe_next = oe_reg;
    // frozen clock holds the pipe, stretching the burst
    if (run) begin
      pd_next[0] = store[cur_idx];
      pv_next[0] = fetch;
      for (int i = 1; i < RD_LAT; i++) begin
        pd_next[i] = pd_reg[i-1];
        pv_next[i] = pv_reg[i-1];
      end
      oe_next = pv_next[LAST] ? ~dqm_q_reg : '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < RD_LAT; i++) begin
        pd_reg[i] <= '0;
      end
      pv_reg <= '0;
      oe_reg <= '0;
    end else begin
      pd_reg <= pd_next;
      pv_reg <= pv_next;
      oe_reg <= oe_next;
    end
  end

  assign dq_out = pd_reg[LAST];
  assign dq_oe = oe_reg;
  assign bank_open = open_reg;
  assign power_state = power_reg;
  assign suspended = susp_reg;
  assign illegal_cmd = ill_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence dqm_hi_s;
    pins.dqm[0] && pins.cke;
  endsequence

  oe_from_pipe_a: assert property (dq_oe != '0 |-> pv_reg[LAST])
    else $error("data driven with no read scheduled");
  read_mask_a: assert property (dqm_hi_s |-> ##2 !dq_oe[0])
    else $error("masked read byte still driven");
  write_mask_a: assert property (push |-> beat.be == ~pins.dqm)
    else $error("write mask not applied to same beat");
  stop_write_a: assert property (run && cmd == SDC_STOP |-> !push)
    else $error("beat taken on burst stop");
  clock_freeze_a: assert property (!run |=> $stable(bleft_reg) && $stable(dq_oe))
    else $error("state moved while clock frozen");
  act_open_a: assert property (run && cmd == SDC_ACT && pins.bank == 2'h0
    |=> bank_open[0])
    else $error("activate did not open bank");
  pre_all_a: assert property (run && cmd == SDC_PRE && pins.addr[AP_BIT]
    |=> bank_open == '0)
    else $error("precharge all left a bank open");
  pd_exit_a: assert property (power_state == SDC_PDOWN && pins.cke && !pins.cs_n
    |=> illegal_cmd && power_state == SDC_ACTIVE)
    else $error("bad power down exit not flagged");
  self_hold_a: assert property (power_state == SDC_SELF && !pins.cke
    |=> power_state == SDC_SELF)
    else $error("self refresh left with gate low");
endmodule

`default_nettype wire

// >>> verification/sdc_ctrl_model.sv
/*
 memory controller model: drives the command pins and its side of dq.
 assumes the bench calls put once per clock and nothing else drives pins.
*/
`timescale 1ns/1ps
`default_nettype none

module sdc_ctrl_model
  import sdc_pkg::*;
#(
  parameter int TCK_NS = 50
) (
  // clock
  input wire logic clk,
  // toward the device
  output var sdc_pkg::sdc_pins_t pins,
  output logic [sdc_pkg::DQ_W-1:0] dq_drv
);
  // minimum times become whole cycles, rounded up
  function automatic int cyc(input int ns);
    return (ns + TCK_NS - 1) / TCK_NS;
  endfunction

  // slowest grade taken so one model fits all grades
  localparam int T_RRD = cyc(24);
  localparam int T_RC = cyc(90);

  initial begin
    pins = {1'b1, 4'hF, 2'h0, 13'h0, 4'h0};
    dq_drv = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////

  // c is {cs_n, ras_n, cas_n, we_n}; a released bus drives the inverse of its last value each cycle
  task automatic put(input logic [3:0] c, input logic [1:0] ba, input logic [12:0] a,
      input logic [3:0] m, input logic [31:0] d, input logic w, input logic ck);
    @(posedge clk);
    pins <= {ck, c, ba, a, m};
    dq_drv <= w ? d : ~dq_drv;
  endtask
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
/*
 testbench of the sdram command state logic.
 assumes the controller model drives all pins; bench resolves dq.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import sdc_pkg::*;
  localparam int RL = 3;
  localparam int BL = 4;
  localparam logic [3:0] MRS = 4'h0, REF = 4'h1, PRE = 4'h2, ACT = 4'h3;
  localparam logic [3:0] WR = 4'h4, RD = 4'h5, STP = 4'h6, NOP = 4'h7, DES = 4'hF;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  sdc_pins_t pins;
  logic [DQ_W-1:0] dq_drv, dq_out, dq_in;
  logic [BYTES-1:0] dq_oe;
  logic [NUM_BANKS-1:0] bank_open;
  sdc_power_t power_state;
  logic suspended, illegal_cmd, wbuf_ready;
  logic [31:0] q[$];
  int failures = 0;
  int n_checks = 0;

  always #25 clk = ~clk;

  // device wins the byte lanes it enables
  always_comb begin
    for (int i = 0; i < BYTES; i++) begin
      dq_in[8*i +: 8] = dq_oe[i] ? dq_out[8*i +: 8] : dq_drv[8*i +: 8];
    end
  end

  sdc_ctrl_model u_sdc_ctrl_model (.clk(clk), .pins(pins), .dq_drv(dq_drv));

  sdc_core #(.RD_LAT(RL), .BURST_LEN(BL)) u_sdc_core (.clk(clk), .reset_n(reset_n),
    .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .bank_open(bank_open),
    .power_state(power_state), .suspended(suspended), .illegal_cmd(illegal_cmd),
    .wbuf_ready(wbuf_ready));

  ////////////////////////////////////////////////////////////////////////

  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [12:0] a);
    u_sdc_ctrl_model.put(c, ba, a, 4'h0, 32'h0, 1'b0, 1'b1);
  endtask

  task automatic pw(input logic [3:0] c, input logic ck);
    u_sdc_ctrl_model.put(c, 2'h0, 13'h0, 4'h0, 32'h0, 1'b0, ck);
  endtask

  // ends mid-cycle so outputs are settled
  task automatic nop(input int n);
    repeat (n) cmd(NOP, 2'h0, 13'h0);
    @(negedge clk);
  endtask

  task automatic wr(input logic [1:0] ba, input logic [12:0] a, input logic [31:0] b,
      input int n, input logic [3:0] m0);
    for (int k = 0; k < n; k++) begin
      u_sdc_ctrl_model.put(k == 0 ? WR : NOP, ba, a, k == 0 ? m0 : 4'h0, b + 32'(k),
        1'b1, 1'b1);
    end
  endtask

  // a sample counts only if cke was high on the edge before its sampling edge,
  // which is the value put two iterations earlier
  task automatic rd(input logic [1:0] ba, input logic [12:0] a, input int stp,
      input int sus);
    int first;
    logic pk;
    logic pk2;
    logic ck;
    first = 0;
    pk = 1'b1;
    pk2 = 1'b1;
    q.delete();
    cmd(RD, ba, a);
    for (int k = 1; k <= 12; k++) begin
      nop(0);
      if (dq_oe === 4'hF && pk2) begin
        if (first == 0) first = k;
        q.push_back(dq_in);
      end
      if (sus > 0 && k == sus + 2) chk("suspend", suspended, 1'b1);
      ck = !(sus > 0 && (k == sus || k == sus + 1));
      u_sdc_ctrl_model.put(k == stp ? STP : NOP, ba, 13'h0, 4'h0, 32'h0, 1'b0, ck);
      pk2 = pk;
      pk = ck;
    end
    nop(0);
    // sample k stands before controller edge k, the command edge is edge 1
    chk("latency", first - 1, RL);
    chk("idle bus", dq_oe, 4'h0);
  endtask

  task automatic cmpq(input logic [31:0] b, input int lo);
    chk("beats", q.size(), BL);
    for (int k = lo; k < BL; k++) begin
      chk("beat", q[k], b + 32'(k));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk("oe", dq_oe, 4'h0);
    chk("open", bank_open, 4'h0);
    chk("power", power_state, SDC_ACTIVE);
    chk("flags", {suspended, illegal_cmd, wbuf_ready}, 3'h1);
    @(posedge clk);
    reset_n <= 1'b1;
    nop(4);
    cmd(ACT, 2'h0, 13'h0001);
    nop(u_sdc_ctrl_model.T_RRD);
    cmd(ACT, 2'h0, 13'h0001);
    nop(1);
    chk("act twice", illegal_cmd, 1'b1);
    cmd(4'hB, 2'h1, 13'h0001);
    nop(1);
    chk("pulse", illegal_cmd, 1'b0);
    chk("deselect", bank_open, 4'h1);
    cmd(ACT, 2'h1, 13'h0001);
    nop(2);
    chk("open", bank_open, 4'h3);
    wr(2'h0, 13'h000, 32'hA0A0A010, 4, 4'h0);
    nop(1);
    wr(2'h0, 13'h000, 32'h5B5B5B20, 4, 4'h1);
    nop(1);
    wr(2'h0, 13'h008, 32'hD0D0D0D0, 4, 4'h0);
    nop(1);
    // two beats keep column commands apart
    wr(2'h0, 13'h008, 32'hC0C0C0C0, 2, 4'h0);
    wr(2'h0, 13'h00C, 32'hE0E0E0E0, 4, 4'h0);
    nop(1);
    wr(2'h0, 13'h004, 32'hF0F0F0F0, 4, 4'h0);
    nop(1);
    wr(2'h0, 13'h004, 32'h90909090, 1, 4'h0);
    cmd(STP, 2'h0, 13'h0);
    nop(12);
    chk("room", wbuf_ready, 1'b1);
    rd(2'h0, 13'h000, 0, 4);
    cmpq(32'h5B5B5B20, 1);
    chk("masked", q[0], 32'h5B5B5B10);
    rd(2'h0, 13'h008, 0, 0);
    cmpq(32'hD0D0D0D0, 2);
    chk("restart", q[1], 32'hC0C0C0C1);
    rd(2'h0, 13'h004, 0, 0);
    cmpq(32'hF0F0F0F0, 1);
    chk("stop wr", q[0], 32'h90909090);
    rd(2'h0, 13'h004, 1, 0);
    chk("stop rd", q.size(), 1);
    cmd(RD, 2'h0, 13'h000);
    u_sdc_ctrl_model.put(NOP, 2'h0, 13'h0, 4'h1, 32'h0, 1'b0, 1'b1);
    nop(2);
    chk("dqm oe", dq_oe, 4'hE);
    nop(1);
    chk("dqm oe", dq_oe, 4'hF);
    nop(4);
    rd(2'h0, 13'h040C, 0, 0);
    cmpq(32'hE0E0E0E0, 0);
    chk("auto pre", bank_open, 4'h2);
    wr(2'h1, 13'h000, 32'hB0B0B0B0, 2, 4'h0);
    cmd(PRE, 2'h1, 13'h0);
    nop(1);
    chk("pre", bank_open, 4'h0);
    nop(u_sdc_ctrl_model.T_RC);
    cmd(ACT, 2'h1, 13'h0001);
    nop(u_sdc_ctrl_model.T_RRD);
    cmd(ACT, 2'h0, 13'h0001);
    nop(2);
    rd(2'h1, 13'h000, 0, 0);
    chk("pre wr", q[1], 32'hB0B0B0B1);
    chk("pre cut", q[2] !== ~32'hB0B0B0B1, 1'b1);
    cmd(PRE, 2'h0, 13'h0);
    nop(1);
    chk("pre one", bank_open, 4'h2);
    cmd(REF, 2'h0, 13'h0);
    nop(1);
    chk("ref open", illegal_cmd, 1'b1);
    cmd(PRE, 2'h0, 13'h0400);
    nop(1);
    chk("pre all", bank_open, 4'h0);
    cmd(MRS, 2'h0, 13'h0);
    nop(2);
    cmd(REF, 2'h0, 13'h0);
    nop(1);
    chk("ref idle", illegal_cmd, 1'b0);
    nop(u_sdc_ctrl_model.T_RC);
    pw(DES, 1'b0);
    pw(DES, 1'b0);
    nop(0);
    chk("pdown", power_state, SDC_PDOWN);
    pw(DES, 1'b1);
    nop(1);
    chk("pd exit", {power_state, illegal_cmd}, {SDC_ACTIVE, 1'b0});
    nop(1);
    pw(DES, 1'b0);
    pw(NOP, 1'b1);
    nop(1);
    chk("pd bad exit", illegal_cmd, 1'b1);
    nop(1);
    pw(REF, 1'b0);
    pw(DES, 1'b0);
    nop(0);
    chk("self", power_state, SDC_SELF);
    pw(NOP, 1'b1);
    nop(1);
    chk("self exit", {power_state, illegal_cmd}, {SDC_ACTIVE, 1'b0});
    nop(u_sdc_ctrl_model.T_RC);
    pw(REF, 1'b0);
    pw(ACT, 1'b1);
    nop(1);
    chk("self bad exit", illegal_cmd, 1'b1);
    nop(u_sdc_ctrl_model.T_RC);
    stop_test();
  end

  // tests need about 200 cycles; allow ten times that
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule

`default_nettype wire
